// ---- pkg/fasm_pkg.sv ----
`default_nettype none
package fasm_pkg;
	// Sizes of the supervised groups
	localparam int NF = 4;
	localparam int NA = 4;
	localparam int IW = 2;
	localparam int NP = NF + NA + 2;
	localparam int FW = 5;
	localparam int NEV = 3;
	// Register byte offsets
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_FCFG = 8'h04;
	localparam logic [7:0] A_STAT = 8'h08;
	localparam logic [7:0] A_ACK = 8'h0C;
	localparam logic [7:0] A_ISTAT = 8'h10;
	localparam logic [7:0] A_ICLR = 8'h14;
	localparam logic [7:0] A_IEN = 8'h18;
	// Control bit positions and reset value
	localparam int C_SERVO = 0;
	localparam int C_START = 1;
	localparam int C_LOCATE = 2;
	localparam int C_PC_ACT = 3;
	localparam int C_PC_ERR = 4;
	localparam int C_CARD = 5;
	localparam int C_INHIB = 6;
	localparam logic [6:0] CTRL_RST = 7'h02;
	// Per-fault config field: reaction, ack class, encoder flag
	localparam int F_REACT = 0;
	localparam int F_ACK = 2;
	localparam int F_ENC = 4;
	localparam logic [1:0] RC_NONE = 2'h0;
	localparam logic [1:0] RC_RAMP = 2'h1;
	localparam logic [1:0] RC_COAST = 2'h2;
	localparam logic [1:0] RC_QUICK = 2'h3;
	localparam logic [1:0] AK_POWER = 2'h0;
	localparam logic [1:0] AK_INSTANT = 2'h1;
	localparam logic [1:0] AK_GATING = 2'h2;
	// Status register fields
	localparam int ST_FACT = 0;
	localparam int ST_AACT = 4;
	localparam int ST_FFI = 8;
	localparam int ST_FAI = 10;
	localparam int ST_FOK = 12;
	localparam int ST_AOK = 13;
	localparam int ST_ACKD = 14;
	// Interrupt event bits
	localparam int EV_FAULT = 0;
	localparam int EV_ALARM = 1;
	localparam int EV_CLEAR = 2;
	// Display kinds
	localparam logic [1:0] DK_NONE = 2'h0;
	localparam logic [1:0] DK_FAULT = 2'h1;
	localparam logic [1:0] DK_ALARM = 2'h2;
	// Timebase: quarter-second tick, hold-off in ticks
	localparam int CLK_HZ = 25000000;
	localparam int QUARTER_MS = 250;
	localparam int QUARTER_CYC_DEF = CLK_HZ / 1000 * QUARTER_MS;
	localparam int TB_W = 23;
	localparam int HOLD_S = 5;
	localparam int HOLD_TICKS = HOLD_S * 1000 / QUARTER_MS;
	localparam int HW = 5;
	// Carriers
	typedef struct packed {
		logic rdy_green;
		logic rdy_red;
		logic link_green;
		logic link_red;
	} fasm_lamp_t;
	typedef struct packed {
		logic ramp_stop_reaction;
		logic coast_stop_reaction;
		logic quick_stop_reaction;
	} fasm_stop_t;
	typedef struct packed {
		logic [1:0] kind;
		logic [IW-1:0] index;
		logic multi;
	} fasm_disp_t;
endpackage
`default_nettype wire

// ---- hdl/fasm_top.sv ----
// Implementation choices: the register offsets and the APB interface to the registers.
`default_nettype none
module fasm_top
	import fasm_pkg::*;
#(
	parameter int QUARTER_CYC = fasm_pkg::QUARTER_CYC_DEF
)(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [fasm_pkg::NF-1:0] fault_cause,
	input wire logic [fasm_pkg::NA-1:0] alarm_cause,
	input wire logic panel_button,
	input wire logic reset_di,
	output fasm_pkg::fasm_lamp_t lamp,
	output fasm_pkg::fasm_stop_t stop,
	output fasm_pkg::fasm_disp_t disp,
	output logic irq
);
	import fasm_pkg::*;

	typedef struct packed {
		logic [NP-1:0] p1;
		logic [NP-1:0] p2;
		logic [NP-1:0] p3;
		logic [NP-1:0] pf;
		logic rdi_prev;
		logic btn_prev;
		logic [6:0] ctrl;
		logic [NF*FW-1:0] fcfg;
		logic [NF-1:0] latched;
		logic [NF-1:0] acked;
		logic [NA-1:0] aprev;
		logic [IW-1:0] ff_idx;
		logic [IW-1:0] fa_idx;
		logic ff_ok;
		logic fa_ok;
		logic [NEV-1:0] istat;
		logic [NEV-1:0] ien;
		logic [TB_W-1:0] tb_cnt;
		logic [2:0] phase;
		logic [HW-1:0] hold_cnt;
		logic [31:0] prdata;
		logic pslverr;
		logic irq;
		fasm_lamp_t lamp;
		fasm_stop_t stop;
		fasm_disp_t disp;
	} fasm_state_t;

	fasm_state_t s;
	fasm_state_t next_s;
	logic [1:0] rst_q;
	logic rst_ok;

	// Index of the lowest set bit, zero when none
	function automatic logic [IW-1:0] fasm_lowest(input logic [3:0] v);
		fasm_lowest = '0;
		for (int i = 3; i >= 0; i--)
		begin
			if (v[i])
				fasm_lowest = IW'(i);
		end
	endfunction

	// Class field of one fault
	function automatic logic [1:0] fasm_cls(input logic [NF*FW-1:0] c,
		input int i);
		fasm_cls = c[FW*i+F_ACK +: 2];
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Reset release: async assert, two-flop synchronous release
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			rst_q <= 2'h0;
		else
			rst_q <= {rst_q[0], 1'b1};
	end
	assign rst_ok = rst_q[1];

	////////////////////////////////////////////////////////////////////////
	// Decoded views of the current state
	logic [NF-1:0] cause;
	logic [NA-1:0] acause;
	logic btn_rise;
	logic rdi_rise;
	logic wr;
	logic ack_req;
	logic tick;
	logic expire;
	logic inhib;
	logic [NF-1:0] act;
	logic any_fa;

	assign cause = s.pf[NF-1:0];
	assign acause = s.pf[NF+NA-1:NF];
	assign btn_rise = s.pf[NF+NA] & ~s.btn_prev;
	assign rdi_rise = s.pf[NF+NA+1] & ~s.rdi_prev;
	assign wr = psel & penable & pwrite;
	// Software ack and the digital reset input act alike
	assign ack_req = rdi_rise | (wr && paddr == A_ACK && pwdata[0]);
	assign tick = s.tb_cnt == TB_W'(QUARTER_CYC - 1);
	assign expire = tick && s.hold_cnt == HW'(HOLD_TICKS - 1);
	assign inhib = s.ctrl[C_INHIB];
	assign act = s.latched & ~s.acked;
	assign any_fa = (act != '0) || (acause != '0);

	////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb
	begin
		logic [NEV-1:0] ev;
		logic [1:0] cls;
		logic inst;
		logic c_any;
		logic q_any;
		logic r_any;
		ev = '0;
		cls = '0;
		inst = 1'b0;
		c_any = 1'b0;
		q_any = 1'b0;
		r_any = 1'b0;
		next_s = s;

		// Pin synchronisers; a change counts once stages 2 and 3 agree
		next_s.p1 = {reset_di, panel_button, alarm_cause, fault_cause};
		next_s.p2 = s.p1;
		next_s.p3 = s.p2;
		for (int i = 0; i < NP; i++)
		begin
			if (s.p2[i] == s.p3[i])
				next_s.pf[i] = s.p3[i];
		end
		next_s.btn_prev = s.pf[NF+NA];
		next_s.rdi_prev = s.pf[NF+NA+1];

		// Quarter-second timebase; phase bits give 2, 1 and 0.5 Hz
		next_s.tb_cnt = tick ? '0 : s.tb_cnt + 1'b1;
		if (tick)
			next_s.phase = s.phase + 3'h1;

		// Fault latching and acknowledgement per class
		for (int i = 0; i < NF; i++)
		begin
			cls = fasm_cls(s.fcfg, i);
			inst = (cls == AK_INSTANT) || (cls == AK_GATING && inhib);
			if (cause[i] && !s.latched[i])
			begin
				next_s.latched[i] = 1'b1;
				next_s.acked[i] = 1'b0;
				ev[EV_FAULT] = 1'b1;
			end
			else if (s.latched[i] && !cause[i] && inst)
			begin
				next_s.latched[i] = 1'b0;
				next_s.acked[i] = 1'b0;
				ev[EV_CLEAR] = 1'b1;
			end
			else if (s.latched[i] && ack_req && inst)
				next_s.acked[i] = 1'b1;
			// Power-cycle class has no clearing branch at all
			if (expire && s.acked[i] && cause[i])
			begin
				next_s.acked[i] = 1'b0;
				ev[EV_FAULT] = 1'b1;
			end
		end

		// Hold-off timer; any button press or new ack restarts it
		if ((s.acked & cause) == '0 || btn_rise || ack_req)
			next_s.hold_cnt = '0;
		else if (expire)
			next_s.hold_cnt = '0;
		else if (tick)
			next_s.hold_cnt = s.hold_cnt + 1'b1;

		// First fault stays first while it remains active
		if (act == '0)
			next_s.ff_ok = 1'b0;
		else if (!s.ff_ok || !act[s.ff_idx])
		begin
			next_s.ff_idx = fasm_lowest(act);
			next_s.ff_ok = 1'b1;
		end
		// Alarms acknowledge themselves: active equals cause
		if (acause == '0)
			next_s.fa_ok = 1'b0;
		else if (!s.fa_ok || !acause[s.fa_idx])
		begin
			next_s.fa_idx = fasm_lowest(acause);
			next_s.fa_ok = 1'b1;
		end
		next_s.aprev = acause;
		if ((acause & ~s.aprev) != '0)
			ev[EV_ALARM] = 1'b1;

		// Strongest reaction among active faults wins
		for (int i = 0; i < NF; i++)
		begin
			if (act[i])
			begin
				if (s.fcfg[FW*i+F_ENC])
					c_any = 1'b1;
				else if (s.fcfg[FW*i+F_REACT +: 2] == RC_COAST)
					c_any = 1'b1;
				else if (s.fcfg[FW*i+F_REACT +: 2] == RC_QUICK)
					q_any = 1'b1;
				else if (s.fcfg[FW*i+F_REACT +: 2] == RC_RAMP)
					r_any = 1'b1;
			end
		end
		next_s.stop.coast_stop_reaction = c_any;
		next_s.stop.quick_stop_reaction = q_any & ~c_any;
		next_s.stop.ramp_stop_reaction = r_any & ~q_any & ~c_any;

		// Display: faults hide alarms until all are acknowledged
		if (act != '0)
		begin
			next_s.disp.kind = DK_FAULT;
			next_s.disp.index = s.ff_idx;
			next_s.disp.multi = (act & (act - 1'b1)) != '0;
		end
		else if (acause != '0)
		begin
			next_s.disp.kind = DK_ALARM;
			next_s.disp.index = s.fa_idx;
			next_s.disp.multi = (acause & (acause - 1'b1)) != '0;
		end
		else
		begin
			next_s.disp.kind = DK_NONE;
			next_s.disp.index = '0;
			next_s.disp.multi = 1'b0;
		end

		// Drive lamp; orange is red and green together
		next_s.lamp.rdy_green = 1'b0;
		next_s.lamp.rdy_red = 1'b0;
		if (s.ctrl[C_LOCATE])
		begin
			next_s.lamp.rdy_red = 1'b1;
			next_s.lamp.rdy_green = s.phase[1];
		end
		else if (any_fa)
			next_s.lamp.rdy_red = s.phase[1];
		else if (s.ctrl[C_SERVO] && !s.ctrl[C_START])
			next_s.lamp.rdy_green = 1'b1;
		else
			next_s.lamp.rdy_red = 1'b1;

		// Link lamp; an error outranks activity indication
		next_s.lamp.link_green = 1'b0;
		next_s.lamp.link_red = 1'b0;
		if (s.ctrl[C_PC_ERR])
			next_s.lamp.link_red = 1'b1;
		else if (s.ctrl[C_CARD])
			next_s.lamp.link_green = s.phase[0];
		else if (s.ctrl[C_PC_ACT])
			next_s.lamp.link_green = s.phase[2];
		// Otherwise both stay dark

		// APB writes land in the access phase
		if (wr)
		begin
			if (paddr == A_CTRL)
				next_s.ctrl = pwdata[6:0];
			else if (paddr == A_FCFG)
				next_s.fcfg = pwdata[NF*FW-1:0];
			else if (paddr == A_IEN)
				next_s.ien = pwdata[NEV-1:0];
		end

		// Sticky events; a new event beats a clear in the same cycle
		next_s.istat = s.istat;
		if (wr && paddr == A_ICLR)
			next_s.istat = s.istat & ~pwdata[NEV-1:0];
		next_s.istat = next_s.istat | ev;
		next_s.irq = (next_s.istat & s.ien) != '0;

		// Read data is fetched in the setup cycle, one wait-free access
		if (psel && !penable)
		begin
			next_s.prdata = '0;
			next_s.pslverr = 1'b0;
			if (paddr == A_CTRL)
				next_s.prdata[6:0] = s.ctrl;
			else if (paddr == A_FCFG)
				next_s.prdata[NF*FW-1:0] = s.fcfg;
			else if (paddr == A_STAT)
			begin
				next_s.prdata[ST_FACT +: NF] = act;
				next_s.prdata[ST_AACT +: NA] = acause;
				next_s.prdata[ST_FFI +: IW] = s.ff_idx;
				next_s.prdata[ST_FAI +: IW] = s.fa_idx;
				next_s.prdata[ST_FOK] = s.ff_ok;
				next_s.prdata[ST_AOK] = s.fa_ok;
				next_s.prdata[ST_ACKD +: NF] = s.acked;
			end
			else if (paddr == A_ISTAT)
				next_s.prdata[NEV-1:0] = s.istat;
			else if (paddr == A_IEN)
				next_s.prdata[NEV-1:0] = s.ien;
			else if (paddr == A_ACK || paddr == A_ICLR)
				next_s.prdata = '0;
			else
				next_s.pslverr = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge sys_clk or negedge rst_ok)
	begin
		if (!rst_ok)
		begin
			s <= '0;
			s.ctrl <= CTRL_RST;
		end
		else
			s <= next_s;
	end

	// Outputs straight from flops, ready is the handshake term
	assign prdata = s.prdata;
	assign pslverr = s.pslverr;
	assign pready = psel & penable;
	assign lamp = s.lamp;
	assign stop = s.stop;
	assign disp = s.disp;
	assign irq = s.irq;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_ok);

	sequence s_expire0;
		expire && s.acked[0] && cause[0] && !btn_rise && !ack_req;
	endsequence
	sequence s_di_ack0;
		rdi_rise && s.latched[0] && cause[0]
			&& fasm_cls(s.fcfg, 0) == AK_INSTANT;
	endsequence

	property p_power_hold;
		s.latched[1] && fasm_cls(s.fcfg, 1) == AK_POWER |=> s.latched[1];
	endproperty
	a_power_hold: assert property (p_power_hold)
		else $error("power class fault left latch");

	property p_instant_clear;
		s.latched[0] && !cause[0] && fasm_cls(s.fcfg, 0) == AK_INSTANT
			|=> !s.latched[0] ##1 !stop.coast_stop_reaction || act != '0;
	endproperty
	a_instant_clear: assert property (p_instant_clear)
		else $error("instant class fault not cleared");

	property p_gating_hold;
		s.latched[2] && !inhib && fasm_cls(s.fcfg, 2) == AK_GATING
			|=> s.latched[2] && $stable(s.acked[2]);
	endproperty
	a_gating_hold: assert property (p_gating_hold)
		else $error("gating fault changed without inhibit");

	property p_fault_first;
		act != '0 |=> disp.kind == DK_FAULT;
	endproperty
	a_fault_first: assert property (p_fault_first)
		else $error("alarm shown over a fault");

	property p_reraise;
		s_expire0 |=> !s.acked[0] && s.istat[EV_FAULT];
	endproperty
	a_reraise: assert property (p_reraise)
		else $error("persistent fault not raised again");

	property p_di_ack;
		s_di_ack0 |=> s.acked[0] ##1 disp.index != 2'h0 || !act[0];
	endproperty
	a_di_ack: assert property (p_di_ack)
		else $error("reset input did not acknowledge");

	property p_encoder;
		act[3] && s.fcfg[FW*3+F_ENC] |=> stop.coast_stop_reaction
			&& !stop.ramp_stop_reaction;
	endproperty
	a_encoder: assert property (p_encoder)
		else $error("encoder fault not coasting");

	property p_flash;
		any_fa && !s.ctrl[C_LOCATE] |=> lamp.rdy_red == $past(s.phase[1])
			&& !lamp.rdy_green;
	endproperty
	a_flash: assert property (p_flash)
		else $error("fault flash pattern wrong");

	property p_link_err;
		s.ctrl[C_PC_ERR] |=> lamp.link_red && !lamp.link_green;
	endproperty
	a_link_err: assert property (p_link_err)
		else $error("link error lamp not red");

endmodule
`default_nettype wire

// ---- testbench/fasm_panel.sv ----
`default_nettype none
////////////////////////////////////////////////////////////////////////
// Operator panel and controller reset input on the drive's far side
module fasm_panel
(
	input wire logic sys_clk,
	input wire logic ack_req,
	input wire logic press,
	output logic panel_button,
	output logic reset_di
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] hold = 4'h0;
	// Reset pulse stays up 8 cycles, long enough to pass the input sync
	always_ff @(posedge sys_clk)
	begin
		if (ack_req)
			hold <= 4'h8;
		else if (hold != 4'h0)
			hold <= hold - 4'h1;
	end
	// Controller acknowledges faults by raising the reset input
	assign reset_di = (hold != 4'h0);
	assign panel_button = press;
endmodule
`default_nettype wire

// ---- testbench/fault_alarm_status_manager_bench.sv ----
`default_nettype none
module fault_alarm_status_manager_bench
	import fasm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [6:0] ctrl;
		logic [3:0] lit;
		logic [31:0] rises;
	} fasm_row_t;
	logic sys_clk = 1'h0;
	logic reset_n = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic ack_req = 1'h0;
	logic press = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd_data;
	logic pready, pslverr, rd_err, panel_button, reset_di, irq;
	logic [NF-1:0] fault_cause = '0;
	logic [NA-1:0] alarm_cause = '0;
	logic [3:0] lit;
	logic [31:0] rises;
	fasm_lamp_t lamp;
	fasm_stop_t stop;
	fasm_disp_t disp;
	int error_cnt = 0;
	int comparisons = 0;
	int cyc = 0;
	// Steady, 2 Hz, 1 Hz and 0.5 Hz give 0, 16, 8, 4 rises in 256 cycles
	fasm_row_t rows [8] = '{
		'{7'h01, 4'h8, 32'h0}, '{7'h00, 4'h4, 32'h0},
		'{7'h02, 4'h4, 32'h0}, '{7'h05, 4'hC, 32'h08000000},
		'{7'h09, 4'hA, 32'h00000400}, '{7'h21, 4'hA, 32'h00001000},
		'{7'h10, 4'h5, 32'h0}, '{7'h38, 4'h5, 32'h0}};

	always #20 sys_clk = ~sys_clk;

	fasm_top #(.QUARTER_CYC(8)) dut (.sys_clk(sys_clk), .reset_n(reset_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fault_cause(fault_cause),
		.alarm_cause(alarm_cause), .panel_button(panel_button),
		.reset_di(reset_di), .lamp(lamp), .stop(stop), .disp(disp),
		.irq(irq));
	fasm_panel u_panel (.sys_clk(sys_clk), .ack_req(ack_req),
		.press(press), .panel_button(panel_button), .reset_di(reset_di));

	////////////////////////////////////////////////////////////////////
	task end_of_test;
		$display("comparisons %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Hang guard well above the expected run length
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			end_of_test();
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	// One APB transfer; waits on pready, never on a fixed count
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'h1;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (pready !== 1'h1 && n < 16);
		// A missing answer counts as a mismatch
		if (pready !== 1'h1)
			error_cnt++;
		rd_data = prdata;
		rd_err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task settle(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// Counts rising edges per lamp over 256 cycles and which lamps lit
	task meas;
		logic [3:0] p;
		p = lamp;
		lit = 4'h0;
		rises = 32'h0;
		repeat (256)
		begin
			@(posedge sys_clk);
			for (int i = 0; i < 4; i++)
				if (lamp[i] && !p[i])
					rises[i*8+:8] = rises[i*8+:8] + 8'h01;
			lit = lit | lamp;
			p = lamp;
		end
	endtask

	////////////////////////////////////////////////////////////////////
	initial
	begin
		settle(6);
		reset_n <= 1'h1;
		settle(4);
		apb(1'h0, A_CTRL, 32'h0);
		chk(rd_data, 32'h2, "ctrl reset");
		apb(1'h0, 8'h20, 32'h0);
		chk(rd_err, 1'h1, "unmapped");
		for (int r = 0; r < 8; r++)
		begin
			apb(1'h1, A_CTRL, rows[r].ctrl);
			settle(8);
			meas();
			chk(lit, rows[r].lit, "lamp lit");
			chk(rises, rows[r].rises, "lamp rate");
		end
		// Alarm flash, then locate overriding it
		alarm_cause <= 4'h1;
		apb(1'h1, A_CTRL, 32'h1);
		settle(12);
		meas();
		chk({lit, rises}, {4'h4, 32'h00080000}, "alarm");
		apb(1'h1, A_CTRL, 32'h5);
		settle(8);
		meas();
		chk({lit, rises}, {4'hC, 32'h08000000}, "locate");
		alarm_cause <= 4'h0;
		apb(1'h1, A_FCFG, 32'hA2C45);
		apb(1'h1, A_IEN, 32'h1);
		apb(1'h1, A_ICLR, 32'h7);
		// Ramp fault with instant clear, interrupt raise and clear
		fault_cause <= 4'h1;
		settle(12);
		chk(stop, 3'h4, "ramp");
		chk(disp, {DK_FAULT, 2'h0, 1'h0}, "disp f0");
		chk(irq, 1'h1, "irq set");
		apb(1'h0, A_ISTAT, 32'h0);
		chk(rd_data[2:0], 3'h1, "istat");
		apb(1'h1, A_ICLR, 32'h7);
		settle(3);
		chk(irq, 1'h0, "irq clr");
		ack_req <= 1'h1;
		settle(1);
		ack_req <= 1'h0;
		settle(12);
		apb(1'h0, A_STAT, 32'h0);
		chk(rd_data[14], 1'h1, "acked");
		settle(100);
		apb(1'h0, A_STAT, 32'h0);
		chk(rd_data[14], 1'h1, "still acked");
		// A panel press restarts the hold-off
		press <= 1'h1;
		settle(8);
		press <= 1'h0;
		settle(100);
		apb(1'h0, A_STAT, 32'h0);
		chk(rd_data[14], 1'h1, "press holds off");
		settle(100);
		apb(1'h0, A_STAT, 32'h0);
		chk(rd_data[14], 1'h0, "re-raised");
		fault_cause <= 4'h0;
		settle(12);
		apb(1'h0, A_STAT, 32'h0);
		chk({rd_data[3:0], stop}, 7'h00, "instant");
		// Masked alarm event
		apb(1'h1, A_ICLR, 32'h7);
		alarm_cause <= 4'h2;
		settle(12);
		chk(irq, 1'h0, "masked");
		alarm_cause <= 4'h0;
		// Coast fault latched after cause is gone
		fault_cause <= 4'h2;
		settle(12);
		chk(stop, 3'h2, "coast");
		fault_cause <= 4'h0;
		alarm_cause <= 4'h1;
		settle(12);
		apb(1'h0, A_STAT, 32'h0);
		chk(rd_data[1], 1'h1, "power latched");
		chk(disp.kind, DK_FAULT, "fault first");
		fault_cause <= 4'h1;
		settle(12);
		chk(disp[2:0], 3'h3, "first of many");
		fault_cause <= 4'h0;
		alarm_cause <= 4'h0;
		reset_n <= 1'h0;
		settle(3);
		reset_n <= 1'h1;
		settle(6);
		apb(1'h0, A_STAT, 32'h0);
		chk(rd_data[3:0], 4'h0, "power cycle");
		apb(1'h1, A_FCFG, 32'hA2C45);
		// Quick fault gated by pulse inhibit
		fault_cause <= 4'h4;
		settle(12);
		chk(stop, 3'h1, "quick");
		fault_cause <= 4'h0;
		settle(12);
		apb(1'h0, A_STAT, 32'h0);
		chk(rd_data[2], 1'h1, "gated hold");
		apb(1'h1, A_ACK, 32'h1);
		apb(1'h0, A_STAT, 32'h0);
		chk(rd_data[16], 1'h0, "gated ack refused");
		apb(1'h1, A_CTRL, 32'h40);
		settle(12);
		apb(1'h0, A_STAT, 32'h0);
		chk(rd_data[2], 1'h0, "gated clear");
		// Encoder fault forces coast despite reaction none
		fault_cause <= 4'h8;
		settle(12);
		chk(stop, 3'h2, "encoder");
		end_of_test();
	end
endmodule
`default_nettype wire
